// ### hw/assp_top.sv
// Store splitter, peripheral-port shaper, lane swizzle and lock release for the core's bus ports.
module assp_top
  import assp_pkg::*;
(
  // Clock, reset and enable
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        ce,
  // Endianness control bits
  input  wire logic        sysctl_u,
  input  wire logic        sysctl_b,
  input  wire logic        sysctl_e,
  // Core request
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire logic        req_periph,
  input  wire logic        req_write,
  input  wire logic        req_lock,
  input  wire logic [1:0]  req_size,
  input  wire logic [4:0]  req_words,
  input  wire logic [31:0] req_addr,
  input  wire logic        swap_rd_abort,
  // Data port address channel
  output logic             dp_avalid,
  input  wire logic        dp_aready,
  output logic             dp_awrite,
  output logic [31:0]      dp_addr,
  output logic [1:0]       dp_burst,
  output logic [2:0]       dp_size,
  output logic [3:0]       dp_len,
  output logic [7:0]       dp_strb,
  output logic [1:0]       dp_lock,
  // Peripheral port address channel
  output logic             pp_avalid,
  input  wire logic        pp_aready,
  output logic             pp_awrite,
  output logic [31:0]      periph_addr,
  output logic [1:0]       periph_burst_type,
  output logic [2:0]       periph_transfer_size,
  output logic [3:0]       periph_burst_length,
  output logic [3:0]       periph_write_strobe,
  output logic [1:0]       pp_lock,
  // Write data beat
  input  wire logic        core_wvalid,
  output logic             core_wready,
  input  wire logic [1:0]  core_wsize,
  input  wire logic [63:0] core_wdata,
  input  wire logic [7:0]  core_wstrb,
  output logic             bus_wvalid,
  input  wire logic        bus_wready,
  output logic [63:0]      bus_wdata,
  output logic [7:0]       bus_wstrb
);

  typedef enum logic [1:0] {
    ASSP_IDLE,
    ASSP_ISSUE
  } assp_fsm_e;

  typedef struct packed {
    assp_fsm_e   fsm;
    logic [31:0] cur_addr;
    logic [4:0]  left;
    logic        periph;
    logic        write;
    logic        lock_pend;
    logic        lock_periph;
    logic [31:0] lock_addr;
    logic        dummy_pend;
    logic        req_ready;
    logic        dp_avalid;
    logic        dp_awrite;
    logic [31:0] dp_addr;
    logic [2:0]  dp_size;
    logic [3:0]  dp_len;
    logic [7:0]  dp_strb;
    logic [1:0]  dp_lock;
    logic        pp_avalid;
    logic        pp_awrite;
    logic [31:0] pp_addr;
    logic [2:0]  pp_size;
    logic [3:0]  pp_len;
    logic [3:0]  pp_strb;
    logic [1:0]  pp_lock;
    logic        core_wready;
    logic        w_valid;
    logic [63:0] w_data;
    logic [7:0]  w_strb;
  } assp_state_s;

  assp_state_s  s_r;
  assp_state_s  s_nxt;
  assp_endian_e mode;
  logic [63:0]  swz_data;
  logic [7:0]   swz_strb;
  logic         hs_dp;
  logic         hs_pp;

  // Data-port piece: {words, size, len, first strobe} for a start word and words left.
  function automatic logic [19:0] dp_piece(input logic [2:0] k, input logic [4:0] left,
                                           input logic first);
    logic [4:0] room;
    logic [4:0] w;
    room = first ? (ASSP_LINE_WORDS - {2'h0, k}) : ASSP_LINE_WORDS;
    w    = (left < room) ? left : room;
    if (!k[0] && !w[0])
      dp_piece = {w, ASSP_SIZE_64, 4'((w >> 1) - 5'h01), ASSP_STRB64_ALL};
    else
      dp_piece = {w, ASSP_SIZE_32, 4'(w - 5'h01), k[0] ? ASSP_STRB64_HIGH : ASSP_STRB64_LOW};
  endfunction

  // Peripheral piece: {words, size, len, strobe}; sub-word accesses are one beat.
  function automatic logic [15:0] pp_piece(input logic [1:0] lane, input logic [1:0] sz,
                                           input logic [4:0] left, input logic wr);
    logic [4:0] w;
    logic [3:0] st;
    w = (left < ASSP_PP_MAX_BEATS) ? left : ASSP_PP_MAX_BEATS;
    if (sz == ASSP_ACC_BYTE)
      pp_piece = {5'h01, ASSP_SIZE_8, 4'h0, ASSP_STRB32_BYTE << lane};
    else if (sz == ASSP_ACC_HALF)
      pp_piece = {5'h01, ASSP_SIZE_16, 4'h0, ASSP_STRB32_HALF << {lane[1], 1'b0}};
    else
      pp_piece = {w, ASSP_SIZE_32, 4'(w - 5'h01), ASSP_STRB32_ALL};
    st = wr ? pp_piece[3:0] : ASSP_STRB32_NONE;
    pp_piece[3:0] = st;
  endfunction

  // Mode select from the control bits.
  always_comb
  begin
    if (sysctl_e)
      mode = ASSP_END_BYTE_INV;
    else if (sysctl_b && !sysctl_u)
      mode = ASSP_END_WORD_INV;
    else
      mode = ASSP_END_LE;
  end

  assp_lane_swizzle #(
    .NWORDS   (2)
  ) u_swizzle (
    .mode     (mode),
    .acc_size (core_wsize),
    .in_data  (core_wdata),
    .in_strb  (core_wstrb),
    .out_data (swz_data),
    .out_strb (swz_strb)
  );

  assign hs_dp = s_r.dp_avalid && dp_aready;
  assign hs_pp = s_r.pp_avalid && pp_aready;

  always_comb
  begin
    logic [19:0] dpc;
    logic [15:0] ppc;
    logic [31:0] a;
    logic [4:0]  cnt;
    s_nxt = s_r;
    dpc   = '0;
    ppc   = '0;
    a     = '0;
    cnt   = '0;
    if (hs_dp)
      s_nxt.dp_avalid = 1'b0;
    if (hs_pp)
      s_nxt.pp_avalid = 1'b0;
    case (s_r.fsm)
      ASSP_IDLE:
      begin
        if (s_r.dummy_pend)
        begin
          // Unlocked write with no strobes releases the interconnect lock.
          s_nxt.dummy_pend = 1'b0;
          s_nxt.lock_pend  = 1'b0;
          s_nxt.left       = 5'h00;
          s_nxt.fsm        = ASSP_ISSUE;
          if (s_r.lock_periph)
          begin
            s_nxt.pp_avalid = 1'b1;
            s_nxt.pp_awrite = 1'b1;
            s_nxt.pp_addr   = s_r.lock_addr;
            s_nxt.pp_size   = ASSP_SIZE_32;
            s_nxt.pp_len    = 4'h0;
            s_nxt.pp_strb   = ASSP_STRB32_NONE;
            s_nxt.pp_lock   = ASSP_LOCK_NORMAL;
          end
          else
          begin
            s_nxt.dp_avalid = 1'b1;
            s_nxt.dp_awrite = 1'b1;
            s_nxt.dp_addr   = s_r.lock_addr;
            s_nxt.dp_size   = ASSP_SIZE_32;
            s_nxt.dp_len    = 4'h0;
            s_nxt.dp_strb   = 8'h00;
            s_nxt.dp_lock   = ASSP_LOCK_NORMAL;
          end
        end
        else if (req_valid && s_r.req_ready)
        begin
          s_nxt.periph = req_periph;
          s_nxt.write  = req_write;
          s_nxt.fsm    = ASSP_ISSUE;
          cnt = (req_words == 5'h00) ? 5'h01 : req_words;
          if (req_lock)
          begin
            s_nxt.lock_pend   = 1'b1;
            s_nxt.lock_periph = req_periph;
            s_nxt.lock_addr   = req_addr;
          end
          else
            s_nxt.lock_pend = 1'b0;
          if (req_periph)
          begin
            // Low address bits cleared to the access size.
            if (req_size == ASSP_ACC_BYTE)
              a = req_addr;
            else if (req_size == ASSP_ACC_HALF)
              a = {req_addr[31:1], 1'b0};
            else
              a = {req_addr[31:2], 2'h0};
            ppc = pp_piece(a[1:0], req_size, cnt, req_write);
            s_nxt.pp_avalid = 1'b1;
            s_nxt.pp_awrite = req_write;
            s_nxt.pp_addr   = a;
            s_nxt.pp_size   = ppc[10:8];
            s_nxt.pp_len    = ppc[7:4];
            s_nxt.pp_strb   = ppc[3:0];
            s_nxt.pp_lock   = req_lock ? ASSP_LOCK_LOCKED : ASSP_LOCK_NORMAL;
            s_nxt.cur_addr  = a;
            s_nxt.left      = (req_size == ASSP_ACC_WORD) ? cnt - ppc[15:11] : 5'h00;
          end
          else
          begin
            // Start piece covers the words up to the end of the line.
            a   = {req_addr[31:2], 2'h0};
            dpc = dp_piece(a[4:2], cnt, 1'b1);
            s_nxt.dp_avalid = 1'b1;
            s_nxt.dp_awrite = req_write;
            s_nxt.dp_addr   = a;
            s_nxt.dp_size   = dpc[14:12];
            s_nxt.dp_len    = dpc[11:8];
            s_nxt.dp_strb   = req_write ? dpc[7:0] : 8'h00;
            s_nxt.dp_lock   = req_lock ? ASSP_LOCK_LOCKED : ASSP_LOCK_NORMAL;
            s_nxt.cur_addr  = {a[31:ASSP_LINE_LSB], 5'h00};
            s_nxt.left      = cnt - dpc[19:15];
          end
        end
      end
      ASSP_ISSUE:
      begin
        if ((hs_dp && !s_r.periph) || (hs_pp && s_r.periph) || hs_dp || hs_pp)
        begin
          if (s_r.left == 5'h00)
            s_nxt.fsm = ASSP_IDLE;
          else if (s_r.periph)
          begin
            a   = s_r.cur_addr + ASSP_PP_STEP;
            ppc = pp_piece(2'h0, ASSP_ACC_WORD, s_r.left, s_r.write);
            s_nxt.pp_avalid = 1'b1;
            s_nxt.pp_addr   = a;
            s_nxt.pp_size   = ppc[10:8];
            s_nxt.pp_len    = ppc[7:4];
            s_nxt.pp_strb   = ppc[3:0];
            s_nxt.pp_lock   = ASSP_LOCK_NORMAL;
            s_nxt.cur_addr  = a;
            s_nxt.left      = s_r.left - ppc[15:11];
          end
          else
          begin
            // Later pieces wrap to the line base, issued back to back.
            dpc = dp_piece(3'h0, s_r.left, 1'b0);
            s_nxt.dp_avalid = 1'b1;
            s_nxt.dp_addr   = s_r.cur_addr;
            s_nxt.dp_size   = dpc[14:12];
            s_nxt.dp_len    = dpc[11:8];
            s_nxt.dp_strb   = s_r.write ? dpc[7:0] : 8'h00;
            s_nxt.dp_lock   = ASSP_LOCK_NORMAL;
            s_nxt.left      = s_r.left - dpc[19:15];
          end
        end
      end
      default:
        s_nxt.fsm = ASSP_IDLE;
    endcase
    // An abort landing with the clear keeps the dummy pending.
    if (swap_rd_abort && s_r.lock_pend)
      s_nxt.dummy_pend = 1'b1;
    s_nxt.req_ready = (s_nxt.fsm == ASSP_IDLE) && !s_nxt.dummy_pend;
    // One-entry write beat stage; half rate is traded for a registered ready.
    if (s_r.w_valid && bus_wready)
      s_nxt.w_valid = 1'b0;
    if (core_wvalid && s_r.core_wready)
    begin
      s_nxt.w_valid = 1'b1;
      s_nxt.w_data  = swz_data;
      s_nxt.w_strb  = swz_strb;
    end
    s_nxt.core_wready = !s_nxt.w_valid;
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      s_r <= '0;
    else if (ce)
      s_r <= s_nxt;
  end

  assign req_ready            = s_r.req_ready;
  assign dp_avalid            = s_r.dp_avalid;
  assign dp_awrite            = s_r.dp_awrite;
  assign dp_addr              = s_r.dp_addr;
  assign dp_burst             = ASSP_BURST_INCR;
  assign dp_size              = s_r.dp_size;
  assign dp_len               = s_r.dp_len;
  assign dp_strb              = s_r.dp_strb;
  assign dp_lock              = s_r.dp_lock;
  assign pp_avalid            = s_r.pp_avalid;
  assign pp_awrite            = s_r.pp_awrite;
  assign periph_addr          = s_r.pp_addr;
  assign periph_burst_type    = ASSP_BURST_INCR;
  assign periph_transfer_size = s_r.pp_size;
  assign periph_burst_length  = s_r.pp_len;
  assign periph_write_strobe  = s_r.pp_strb;
  assign pp_lock              = s_r.pp_lock;
  assign core_wready          = s_r.core_wready;
  assign bus_wvalid           = s_r.w_valid;
  assign bus_wdata            = s_r.w_data;
  assign bus_wstrb            = s_r.w_strb;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_pp_short_burst: assert property (pp_avalid |-> periph_burst_length <= 4'h1)
    else $error("peripheral burst longer than two beats");
  a_pp_aligned: assert property (pp_avalid && periph_transfer_size == ASSP_SIZE_32
                                 |-> periph_addr[1:0] == 2'h0)
    else $error("unaligned peripheral word access");
  a_pp_read_strb: assert property (pp_avalid && !pp_awrite
                                   |-> periph_write_strobe == ASSP_STRB32_NONE)
    else $error("strobe driven on a peripheral read");
  a_dp_eight_piece: assert property (dp_avalid && dp_len == 4'h3 && dp_size == ASSP_SIZE_64
    |-> dp_addr[4:0] == 5'h00 && (dp_strb == ASSP_STRB64_ALL || !dp_awrite))
    else $error("eight-word piece misplaced or partial");
  a_dp_hold: assert property (dp_avalid && !dp_aready |=> dp_avalid && $stable(dp_addr))
    else $error("data port request dropped before acceptance");
  a_dummy_normal: assert property (dp_avalid && dp_awrite && dp_strb == 8'h00
                                   |-> dp_lock == ASSP_LOCK_NORMAL)
    else $error("dummy write carries a lock");
  a_split_wrap: assert property (ce && hs_dp && s_r.left != 5'h00 && !s_r.periph
    |=> dp_avalid && dp_addr[4:0] == 5'h00 && dp_addr[31:5] == $past(dp_addr[31:5]))
    else $error("later split piece not at line base");
  a_pp_step: assert property (ce && hs_pp && s_r.left != 5'h00
    |=> pp_avalid && periph_addr == $past(periph_addr) + ASSP_PP_STEP)
    else $error("peripheral burst step is not eight bytes");

  c_three_piece: cover property (hs_dp && ce ##1 hs_dp && ce ##1 hs_dp && ce && dp_addr[4:0] == 5'h00);
  c_pp_two_beat: cover property (hs_pp && periph_burst_length == 4'h1);
  c_dummy_write: cover property (dp_avalid && dp_awrite && dp_strb == 8'h00);

endmodule // assp_top

// ### hw/assp_pkg.sv
// Shared constants and enumerations of the store-split and peripheral-port bridge.
package assp_pkg;

  // Address-channel encodings.
  localparam logic [1:0] ASSP_BURST_INCR  = 2'h1;
  localparam logic [2:0] ASSP_SIZE_8      = 3'h0;
  localparam logic [2:0] ASSP_SIZE_16     = 3'h1;
  localparam logic [2:0] ASSP_SIZE_32     = 3'h2;
  localparam logic [2:0] ASSP_SIZE_64     = 3'h3;
  localparam logic [1:0] ASSP_LOCK_NORMAL = 2'h0;
  localparam logic [1:0] ASSP_LOCK_LOCKED = 2'h2;

  // Core access sizes.
  localparam logic [1:0] ASSP_ACC_BYTE = 2'h0;
  localparam logic [1:0] ASSP_ACC_HALF = 2'h1;
  localparam logic [1:0] ASSP_ACC_WORD = 2'h2;

  // Line geometry and burst limits.
  localparam int          ASSP_LINE_LSB      = 5;
  localparam logic [4:0]  ASSP_LINE_WORDS    = 5'h08;
  localparam logic [4:0]  ASSP_PP_MAX_BEATS  = 5'h02;
  localparam logic [31:0] ASSP_PP_STEP       = 32'h0000_0008;

  // Strobe patterns.
  localparam logic [7:0] ASSP_STRB64_ALL  = 8'hff;
  localparam logic [7:0] ASSP_STRB64_LOW  = 8'h0f;
  localparam logic [7:0] ASSP_STRB64_HIGH = 8'hf0;
  localparam logic [3:0] ASSP_STRB32_ALL  = 4'hf;
  localparam logic [3:0] ASSP_STRB32_HALF = 4'h3;
  localparam logic [3:0] ASSP_STRB32_BYTE = 4'h1;
  localparam logic [3:0] ASSP_STRB32_NONE = 4'h0;

  // Endianness modes.
  typedef enum logic [1:0] {
    ASSP_END_LE,
    ASSP_END_BYTE_INV,
    ASSP_END_WORD_INV
  } assp_endian_e;

endpackage : assp_pkg

// ### hw/assp_lane_swizzle.sv
// Per-word byte-lane and strobe rearrangement for the big-endian modes.
module assp_lane_swizzle
  import assp_pkg::*;
#(
  parameter int NWORDS = 2
)
(
  // Mode and access size
  input  wire assp_endian_e      mode,
  input  wire logic [1:0]        acc_size,
  // Core-side beat
  input  wire logic [NWORDS*32-1:0] in_data,
  input  wire logic [NWORDS*4-1:0]  in_strb,
  // Bus-side beat
  output logic      [NWORDS*32-1:0] out_data,
  output logic      [NWORDS*4-1:0]  out_strb
);

  // Each 32-bit word is handled on its own, so wide beats never reorder across words.
  for (genvar w = 0; w < NWORDS; w++)
  begin : g_word
    logic [31:0] d;
    logic [3:0]  s;
    logic [31:0] rd;
    logic [3:0]  rs;
    assign d = in_data[w*32 +: 32];
    assign s = in_strb[w*4 +: 4];
    always_comb
    begin
      rd = d;
      rs = s;
      case (mode)
        ASSP_END_BYTE_INV:
        begin
          // Data reversed within the access; strobes keep their lanes.
          if (acc_size == ASSP_ACC_WORD)
            rd = {d[7:0], d[15:8], d[23:16], d[31:24]};
          else if (acc_size == ASSP_ACC_HALF)
            rd = {d[23:16], d[31:24], d[7:0], d[15:8]};
        end
        ASSP_END_WORD_INV:
        begin
          // Sub-word lanes mirrored so software keeps its word-invariant image.
          if (acc_size == ASSP_ACC_HALF)
          begin
            rd = {d[15:0], d[31:16]};
            rs = {s[1:0], s[3:2]};
          end
          else if (acc_size == ASSP_ACC_BYTE)
          begin
            rd = {d[7:0], d[15:8], d[23:16], d[31:24]};
            rs = {s[0], s[1], s[2], s[3]};
          end
        end
        default:
        begin
          rd = d;
          rs = s;
        end
      endcase
    end
    assign out_data[w*32 +: 32] = rd;
    assign out_strb[w*4 +: 4]   = rs;
  end

endmodule // assp_lane_swizzle

// ### verification/assp_axi_slave_model.sv
// Far-side interconnect model that accepts descriptors and write beats, promptly or with stalls.
module assp_axi_slave_model
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  // Timing control
  input  wire logic slow,
  // Acceptance outputs
  output logic      dp_aready,
  output logic      pp_aready,
  output logic      bus_wready
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [1:0] tick_r;

  // Stalling holds each ready low three cycles in four, so requests must wait it out.
  always @(posedge clk)
  begin
    tick_r     <= reset_n ? tick_r + 2'h1 : 2'h0;
    dp_aready  <= !slow || tick_r == 2'h2;
    pp_aready  <= !slow || tick_r == 2'h0;
    bus_wready <= !slow || tick_r == 2'h1;
  end
endmodule // assp_axi_slave_model

// ### verification/assp_top_tb_top.sv
// Self-checking testbench of the store splitter, peripheral shaper, lane swizzle and lock release.
module assp_top_tb_top;
  import assp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk, reset_n, ce, ce_gap, slow, sysctl_u, sysctl_b, sysctl_e;
  logic        req_valid, req_ready, req_periph, req_write, req_lock, swap_rd_abort;
  logic        dp_avalid, dp_aready, dp_awrite, pp_avalid, pp_aready, pp_awrite;
  logic        core_wvalid, core_wready, bus_wvalid, bus_wready;
  logic [1:0]  req_size, dp_burst, dp_lock, periph_burst_type, pp_lock, core_wsize;
  logic [2:0]  dp_size, periph_transfer_size;
  logic [3:0]  dp_len, periph_burst_length, periph_write_strobe;
  logic [4:0]  req_words;
  logic [7:0]  dp_strb, core_wstrb, bus_wstrb;
  logic [31:0] req_addr, dp_addr, periph_addr;
  logic [63:0] core_wdata, bus_wdata;
  logic [51:0] got_q[$];
  logic [51:0] exp_q[$];
  int          err_total, num_checks, cyc;

  assp_top dut (
    .clk, .reset_n, .ce, .sysctl_u, .sysctl_b, .sysctl_e,
    .req_valid, .req_ready, .req_periph, .req_write, .req_lock, .req_size, .req_words,
    .req_addr, .swap_rd_abort, .dp_avalid, .dp_aready, .dp_awrite, .dp_addr, .dp_burst,
    .dp_size, .dp_len, .dp_strb, .dp_lock, .pp_avalid, .pp_aready, .pp_awrite, .periph_addr,
    .periph_burst_type, .periph_transfer_size, .periph_burst_length, .periph_write_strobe,
    .pp_lock, .core_wvalid, .core_wready, .core_wsize, .core_wdata, .core_wstrb,
    .bus_wvalid, .bus_wready, .bus_wdata, .bus_wstrb
  );

  assp_axi_slave_model far_side (.clk, .reset_n, .slow, .dp_aready, .pp_aready, .bus_wready);

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Only descriptors that really cross the channel are logged, in the order they leave.
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    ce  <= ce_gap ? ~ce : 1'b1;
    if (ce === 1'b1 && dp_avalid === 1'b1 && dp_aready === 1'b1)
      got_q.push_back({dp_awrite, dp_addr, dp_burst, dp_size, dp_len, dp_strb, dp_lock});
    if (ce === 1'b1 && pp_avalid === 1'b1 && pp_aready === 1'b1)
      got_q.push_back({pp_awrite, periph_addr, periph_burst_type, periph_transfer_size,
                       periph_burst_length, 4'h0, periph_write_strobe, pp_lock});
    if (cyc == 40000)
    begin
      err_total++;
      conclude();
    end
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("checks=%0d mismatches=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  function automatic void push_exp(input logic wr, input logic [31:0] a, input logic [2:0] sz,
                                   input logic [3:0] len, input logic [7:0] s,
                                   input logic [1:0] lk);
    exp_q.push_back({wr, a, ASSP_BURST_INCR, sz, len, s, lk});
  endfunction

  task automatic cmp_q();
    check(64'(got_q.size()), 64'(exp_q.size()));
    foreach (exp_q[i])
      check((i < got_q.size()) ? 64'(got_q[i]) : 64'h0, 64'(exp_q[i]));
    got_q.delete();
    exp_q.delete();
  endtask

  task automatic wait_ready();
    int i;
    i = 0;
    do
    begin
      @(posedge clk);
      i++;
    end
    while (req_ready !== 1'b1 && i < 300);
  endtask

  task automatic issue(input logic p, input logic wr, input logic lk, input logic [1:0] sz,
                       input int n, input logic [31:0] a);
    int i;
    i = 0;
    req_valid  <= 1'b1;
    req_periph <= p;
    req_write  <= wr;
    req_lock   <= lk;
    req_size   <= sz;
    req_words  <= 5'(n);
    req_addr   <= a;
    do
    begin
      @(posedge clk);
      i++;
    end
    while (!(req_ready === 1'b1 && ce === 1'b1) && i < 300);
    req_valid <= 1'b0;
    wait_ready();
  endtask

  // Data-port multiple store or load of n words starting at word k of a line.
  task automatic split_case(input int n, input int k, input logic wr);
    logic [31:0] a, pa;
    int          left, w, kk;
    logic        wide;
    a = 32'h0000_1000 + 32'(k * 4);
    issue(1'b0, wr, 1'b0, ASSP_ACC_WORD, n, a);
    left = n;
    kk = k;
    pa = a;
    while (left > 0)
    begin
      w = (left < 8 - kk) ? left : 8 - kk;
      wide = !pa[2] && (w % 2 == 0);
      push_exp(wr, pa, wide ? ASSP_SIZE_64 : ASSP_SIZE_32, wide ? 4'(w / 2 - 1) : 4'(w - 1),
               !wr ? 8'h00 : wide ? 8'hff : pa[2] ? 8'hf0 : 8'h0f, ASSP_LOCK_NORMAL);
      left -= w;
      kk = 0;
      pa = {a[31:5], 5'h00};
    end
    cmp_q();
  endtask

  task automatic periph_case(input logic wr, input logic [1:0] sz, input int n,
                             input logic [31:0] a);
    logic [31:0] pa;
    int          left;
    issue(1'b1, wr, 1'b0, sz, n, a);
    if (sz != ASSP_ACC_WORD)
      push_exp(wr, a, (sz == ASSP_ACC_HALF) ? ASSP_SIZE_16 : ASSP_SIZE_8, 4'h0,
               !wr ? 8'h00 : (sz == ASSP_ACC_HALF) ? (a[1] ? 8'h0c : 8'h03)
               : 8'(4'h1 << a[1:0]), ASSP_LOCK_NORMAL);
    left = (sz == ASSP_ACC_WORD) ? n : 0;
    pa = a;
    while (left > 0)
    begin
      push_exp(wr, pa, ASSP_SIZE_32, (left > 1) ? 4'h1 : 4'h0, wr ? 8'h0f : 8'h00,
               ASSP_LOCK_NORMAL);
      pa += 32'h8;
      left -= 2;
    end
    cmp_q();
  endtask

  // A locked read is always followed by an unlocked write, the dummy one after an abort.
  task automatic lock_case(input logic p, input logic abort);
    logic [31:0] a;
    a = p ? 32'h0000_0300 : 32'h0000_2040;
    issue(p, 1'b0, 1'b1, ASSP_ACC_WORD, 1, a);
    push_exp(1'b0, a, ASSP_SIZE_32, 4'h0, 8'h00, ASSP_LOCK_LOCKED);
    if (abort)
    begin
      swap_rd_abort <= 1'b1;
      @(posedge clk);
      swap_rd_abort <= 1'b0;
      repeat (3) @(posedge clk);
      wait_ready();
      push_exp(1'b1, a, ASSP_SIZE_32, 4'h0, 8'h00, ASSP_LOCK_NORMAL);
    end
    else
    begin
      issue(p, 1'b1, 1'b0, ASSP_ACC_WORD, 1, a + 32'h4);
      push_exp(1'b1, a + 32'h4, ASSP_SIZE_32, 4'h0, p ? 8'h0f : 8'hf0, ASSP_LOCK_NORMAL);
    end
    cmp_q();
  endtask

  // Expected lanes of one 32-bit word; mode 0 little, 1 byte-invariant, 2 word-invariant.
  function automatic logic [35:0] swz(input logic [31:0] d, input logic [3:0] s,
                                      input logic [1:0] m, input logic [1:0] sz);
    if (m == 2'h1 && sz == ASSP_ACC_WORD)
      return {d[7:0], d[15:8], d[23:16], d[31:24], s};
    if (m == 2'h1 && sz == ASSP_ACC_HALF)
      return {d[23:16], d[31:24], d[7:0], d[15:8], s};
    if (m == 2'h2 && sz == ASSP_ACC_HALF)
      return {d[15:0], d[31:16], s[1:0], s[3:2]};
    if (m == 2'h2 && sz == ASSP_ACC_BYTE)
      return {d[7:0], d[15:8], d[23:16], d[31:24], s[0], s[1], s[2], s[3]};
    return {d, s};
  endfunction

  task automatic beat_case(input logic [1:0] m, input logic [1:0] sz);
    logic [63:0] d;
    logic [7:0]  s;
    logic [35:0] hi, lo;
    int          i;
    d = 64'h0011_2233_4455_6677;
    s = (sz == ASSP_ACC_WORD) ? 8'hff : (sz == ASSP_ACC_HALF) ? 8'hc3 : 8'h21;
    hi = swz(d[63:32], s[7:4], (m == 2'h3) ? 2'h0 : m, sz);
    lo = swz(d[31:0], s[3:0], (m == 2'h3) ? 2'h0 : m, sz);
    sysctl_e <= (m == 2'h1);
    sysctl_b <= m[1];
    sysctl_u <= (m == 2'h3);
    repeat (2) @(posedge clk);
    core_wvalid <= 1'b1;
    core_wsize  <= sz;
    core_wdata  <= d;
    core_wstrb  <= s;
    i = 0;
    do
    begin
      @(posedge clk);
      i++;
    end
    while (!(core_wready === 1'b1 && ce === 1'b1) && i < 300);
    core_wvalid <= 1'b0;
    do
    begin
      @(posedge clk);
      i++;
    end
    while (!(bus_wvalid === 1'b1 && bus_wready === 1'b1 && ce === 1'b1) && i < 600);
    check(bus_wdata, {hi[35:4], lo[35:4]});
    check(64'(bus_wstrb), 64'({hi[3:0], lo[3:0]}));
  endtask

  initial
  begin
    {reset_n, ce_gap, slow, sysctl_u, sysctl_b, sysctl_e} = '0;
    {req_valid, req_periph, req_write, req_lock, swap_rd_abort, core_wvalid} = '0;
    {req_size, req_words, req_addr, core_wsize, core_wdata, core_wstrb} = '0;
    ce = 1'b1;
    cyc = 0;
    err_total = 0;
    num_checks = 0;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    split_case(15, 0, 1'b1);
    split_case(15, 1, 1'b1);
    split_case(15, 2, 1'b1);
    split_case(15, 7, 1'b1);
    split_case(16, 0, 1'b1);
    split_case(16, 1, 1'b1);
    slow <= 1'b1;
    ce_gap <= 1'b1;
    split_case(16, 7, 1'b1);
    ce_gap <= 1'b0;
    split_case(16, 3, 1'b0);
    periph_case(1'b1, ASSP_ACC_WORD, 8, 32'h0000_0200);
    periph_case(1'b1, ASSP_ACC_WORD, 3, 32'h0000_0200);
    periph_case(1'b0, ASSP_ACC_WORD, 3, 32'h0000_0208);
    periph_case(1'b1, ASSP_ACC_HALF, 1, 32'h0000_0200);
    periph_case(1'b1, ASSP_ACC_HALF, 1, 32'h0000_0206);
    periph_case(1'b1, ASSP_ACC_BYTE, 1, 32'h0000_020b);
    for (int m = 0; m < 4; m++)
      for (int sz = 0; sz < 3; sz++)
        beat_case(2'(m), 2'(sz));
    for (int p = 0; p < 2; p++)
    begin
      lock_case(1'(p), 1'b1);
      lock_case(1'(p), 1'b0);
    end
    conclude();
  end
endmodule // assp_top_tb_top
